// >>> pkg/embp_pkg.sv
package embp_pkg;
   // register indices on the plain register port
   localparam logic [23:0] SYS_CTRL_OFS   = 24'hfff000;
   localparam logic [23:0] CS_CTRL1_OFS   = 24'hfff004;
   localparam logic [23:0] DRAM_CTRL_OFS  = 24'hfff008;
   localparam logic [23:0] PIN_SEL_OFS    = 24'hfff00c;
   localparam logic [23:0] STATUS_OFS     = 24'hfff010;
   localparam logic [23:0] PORT_OUT_OFS   = 24'hfff014;
   localparam logic [23:0] PORT_IN_OFS    = 24'hfff018;
   // field positions
   localparam int NARROW_BIT    = 0;  // system_control_reg: narrow_bus_select
   localparam int SLEEP_BIT     = 1;  // system_control_reg: sleep request
   localparam int STROBE_BIT    = 0;  // cs_control_one: strobe_mode_select
   localparam int DWE_EN_BIT    = 0;  // dram_control_reg: write strobe enable
   localparam int PE3_SEL_BIT   = 0;  // pin select: port_e_bit_three dedicated
   localparam int A0_GPIO_BIT   = 1;  // pin select: port_g_bit_one as gpio
   localparam int ACK_GPIO_BIT  = 2;  // pin select: acknowledge pin as gpio
   localparam int ACK_DIR_BIT   = 3;  // pin select: acknowledge pin as output
   localparam int TOP_GPIO_LSB  = 4;  // pin select: four top address lines as gpio
   // reset values
   localparam logic [7:0] SYS_CTRL_RST = 8'h00;
   localparam logic [7:0] CS_CTRL1_RST = 8'h00;
   localparam logic [7:0] DRAM_CTRL_RST = 8'h00;
   localparam logic [7:0] PIN_SEL_RST  = 8'h00;
   // timing: edges from reset release until the first strap sample is synced
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef struct packed {
      logic        valid;   // one-cycle cycle start
      logic        write;
      logic        dram;
      logic        refresh;
      logic        group_b;
      logic        wide;    // chip-select configured 16-bit
      logic        ext_ack; // chip-select uses external acknowledge
      logic [1:0]  lanes;   // bit1 upper, bit0 lower byte
      logic [23:0] addr;
      logic [15:0] dram_addr;
      logic [15:0] wdata;
   } embp_req_t;
endpackage

// >>> hw/embp_ack_sync.sv
`timescale 1ns/1ps
module embp_ack_sync (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic pin_in,
   output logic      pin_sync
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = pin_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign pin_sync = sync_r;
endmodule // embp_ack_sync

// >>> hw/embp_pins.sv
`timescale 1ns/1ps
// What this block does
// - in sleep, address outputs hold the last bus cycle's value
// - after reset the lowest address pin is address, not port bit
// - lines 16..1 carry dram row/column in dram cycles, else address
// - top four address lines default to address, software may regrant them
// - in sleep every data pin gets its own pull-up
// - low data byte is gpio only when narrow bus bit set
// - upper data byte is always data; 8-bit devices sit on it
// - outside group b, byte pins are write enables; 8-bit uses upper only
// - group b strobe mode bit selects write enables or byte data strobes
// - dram write strobe stays high during refresh
// - dram write strobe on shared pin needs port select and enable bit
// - width pin sampled at reset release: low 8-bit, high 16-bit boot
// - after reset width pin is acknowledge input; may become output or gpio
// - acknowledge pin affects only external-acknowledge cycles
// - output enable low during read cycles
// - legacy strobe and read/write pins default to pulled-up inputs
module embp_pins (
   input  wire logic                clk,
   input  wire logic                srst,
   // register port
   input  wire logic [23:0]         reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   // bus cycle from the core
   input  embp_pkg::embp_req_t      req,
   input  wire logic                cycle_end,
   output logic                     cycle_ack,
   output logic [15:0]              rdata,
   // pins
   output logic [23:0]              addr_o,
   output logic [3:0]               top_gpio_oe,
   output logic                     a0_gpio_oe,
   output logic                     oe_n,
   output logic                     lower_write_strobe_n,
   output logic                     upper_write_strobe_n,
   output logic                     pe3_o,
   output logic                     pe3_oe,
   output logic                     serial_port_clock_sel,
   input  wire logic                boot_width_pin_i,
   output logic                     boot_width_pin_o,
   output logic                     boot_width_pin_oe,
   input  wire logic [15:0]         data_i,
   output logic [15:0]              data_o,
   output logic [15:0]              data_oe,
   output logic [15:0]              data_pullup,
   output logic [2:0]               legacy_pullup,
   output logic                     boot_wide
);
   import embp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  sys_r, sys_nxt, cs1_r, cs1_nxt, drc_r, drc_nxt, sel_r, sel_nxt;
   logic [7:0]  pout_r, pout_nxt, rdata_r, rdata_nxt;
   logic        ack_sync;
   logic [1:0]  settle_r, settle_nxt;
   logic        wide_r, wide_nxt;
   logic [15:0] din_meta_r, din_sync_r;

   embp_ack_sync u_ack (
      .clk      (clk),
      .srst     (srst),
      .pin_in   (boot_width_pin_i),
      .pin_sync (ack_sync)
   );

   always_ff @(posedge clk) begin
      din_meta_r <= data_i;
      din_sync_r <= din_meta_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // register file
   always_comb begin
      sys_nxt   = sys_r;
      cs1_nxt   = cs1_r;
      drc_nxt   = drc_r;
      sel_nxt   = sel_r;
      pout_nxt  = pout_r;
      rdata_nxt = 8'h00;
      if (reg_wr) begin
         unique case (reg_addr)
            SYS_CTRL_OFS:  sys_nxt  = reg_wdata;
            CS_CTRL1_OFS:  cs1_nxt  = reg_wdata;
            DRAM_CTRL_OFS: drc_nxt  = reg_wdata;
            PIN_SEL_OFS:   sel_nxt  = reg_wdata;
            PORT_OUT_OFS:  pout_nxt = reg_wdata;
            default:       ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            SYS_CTRL_OFS:  rdata_nxt = sys_r;
            CS_CTRL1_OFS:  rdata_nxt = cs1_r;
            DRAM_CTRL_OFS: rdata_nxt = drc_r;
            PIN_SEL_OFS:   rdata_nxt = sel_r;
            STATUS_OFS:    rdata_nxt = {6'h00, ack_sync, wide_r};
            PORT_OUT_OFS:  rdata_nxt = pout_r;
            PORT_IN_OFS:   rdata_nxt = din_sync_r[7:0];
            default:       rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sys_r   <= SYS_CTRL_RST;
         cs1_r   <= CS_CTRL1_RST;
         drc_r   <= DRAM_CTRL_RST;
         sel_r   <= PIN_SEL_RST;
         pout_r  <= 8'h00;
         rdata_r <= 8'h00;
      end else begin
         sys_r   <= sys_nxt;
         cs1_r   <= cs1_nxt;
         drc_r   <= drc_nxt;
         sel_r   <= sel_nxt;
         pout_r  <= pout_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // strap sampled at first edge after release, latched once synced
   always_comb begin
      settle_nxt = (settle_r == 2'h3) ? settle_r : settle_r + 2'h1;
      wide_nxt   = (settle_r == STRAP_SETTLE) ? ack_sync : wide_r;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         settle_r <= 2'h0;
         wide_r   <= 1'b0;
      end else begin
         settle_r <= settle_nxt;
         wide_r   <= wide_nxt;
      end
   end
   assign boot_wide = wide_r;

   ////////////////////////////////////////////////////////////////////////
   // cycle pin state
   logic        sleep;
   logic        active_r, active_nxt, wr_r, wr_nxt, dram_r, dram_nxt;
   logic        ref_r, ref_nxt, grpb_r, grpb_nxt, wide_cs_r, wide_cs_nxt;
   logic        ext_r, ext_nxt;
   logic [1:0]  lanes_r, lanes_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [15:0] wd_r, wd_nxt, rd_r, rd_nxt;

   assign sleep = sys_r[SLEEP_BIT];

   always_comb begin
      active_nxt  = active_r;
      wr_nxt      = wr_r;
      dram_nxt    = dram_r;
      ref_nxt     = ref_r;
      grpb_nxt    = grpb_r;
      wide_cs_nxt = wide_cs_r;
      ext_nxt     = ext_r;
      lanes_nxt   = lanes_r;
      addr_nxt    = addr_r;
      wd_nxt      = wd_r;
      rd_nxt      = rd_r;
      if (req.valid && !active_r && !sleep) begin
         active_nxt  = 1'b1;
         wr_nxt      = req.write;
         dram_nxt    = req.dram;
         ref_nxt     = req.refresh;
         grpb_nxt    = req.group_b;
         wide_cs_nxt = req.wide;
         ext_nxt     = req.ext_ack;
         lanes_nxt   = req.lanes;
         wd_nxt      = req.wdata;
         addr_nxt    = req.dram ? {req.addr[23:17], req.dram_addr, req.addr[0]} : req.addr;
      end else if (active_r && cycle_end) begin
         active_nxt = 1'b0;
         rd_nxt     = din_sync_r;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         active_r  <= 1'b0;
         wr_r      <= 1'b0;
         dram_r    <= 1'b0;
         ref_r     <= 1'b0;
         grpb_r    <= 1'b0;
         wide_cs_r <= 1'b0;
         ext_r     <= 1'b0;
         lanes_r   <= 2'h0;
         addr_r    <= 24'h000000;
         wd_r      <= 16'h0000;
         rd_r      <= 16'h0000;
      end else begin
         active_r  <= active_nxt;
         wr_r      <= wr_nxt;
         dram_r    <= dram_nxt;
         ref_r     <= ref_nxt;
         grpb_r    <= grpb_nxt;
         wide_cs_r <= wide_cs_nxt;
         ext_r     <= ext_nxt;
         lanes_r   <= lanes_nxt;
         addr_r    <= addr_nxt;
         wd_r      <= wd_nxt;
         rd_r      <= rd_nxt;
      end
   end

   assign addr_o      = addr_r;
   assign rdata       = rd_r;
   assign top_gpio_oe = sel_r[TOP_GPIO_LSB +: 4] & pout_r[7:4];
   assign a0_gpio_oe  = sel_r[A0_GPIO_BIT] & pout_r[0];

   ////////////////////////////////////////////////////////////////////////
   logic do_wr, strobe_mode, lo_en, up_en, narrow;
   assign do_wr       = active_r && wr_r && !ref_r;
   assign strobe_mode = grpb_r && cs1_r[STROBE_BIT];
   assign narrow      = sys_r[NARROW_BIT];
   // narrow chip-select steers all writes to upper strobe
   assign up_en = wide_cs_r ? lanes_r[1] : (lanes_r != 2'h0);
   assign lo_en = wide_cs_r & lanes_r[0];

   always_comb begin
      lower_write_strobe_n = 1'b1;
      upper_write_strobe_n = 1'b1;
      if (strobe_mode) begin
         // byte data strobes on any non-refresh group b access
         lower_write_strobe_n = !(active_r && !ref_r && lo_en);
         upper_write_strobe_n = !(active_r && !ref_r && up_en);
      end else if (do_wr) begin
         lower_write_strobe_n = !lo_en;
         upper_write_strobe_n = !up_en;
      end
   end

   assign oe_n = !(active_r && !wr_r && !ref_r);

   logic dwe_sel;
   assign dwe_sel               = sel_r[PE3_SEL_BIT] && drc_r[DWE_EN_BIT];
   assign pe3_o                 = !(do_wr && dram_r);
   assign pe3_oe                = dwe_sel;
   assign serial_port_clock_sel = !dwe_sel;

   assign cycle_ack = active_r && (ext_r ? !ack_sync : 1'b1)
                      && !sel_r[ACK_GPIO_BIT] && !sel_r[ACK_DIR_BIT] ? 1'b1
                      : (active_r && !ext_r);
   assign boot_width_pin_oe = sel_r[ACK_DIR_BIT];
   assign boot_width_pin_o  = pout_r[1];

   always_comb begin
      data_o  = 16'h0000;
      data_oe = 16'h0000;
      if (do_wr && !sleep) begin
         data_o[15:8]  = (wide_cs_r || narrow) ? wd_r[15:8] : wd_r[7:0];
         data_oe[15:8] = 8'hff;
         data_o[7:0]   = wd_r[7:0];
         data_oe[7:0]  = narrow ? 8'h00 : 8'hff;
      end
      if (narrow) begin
         data_o[7:0]  = pout_r;
         data_oe[7:0] = sleep ? 8'h00 : pout_r;
      end
   end
   assign data_pullup   = sleep ? 16'hffff : 16'h0000;
   assign legacy_pullup = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   property p_sleep_hold;
      @(posedge clk) disable iff (srst) sleep && $past(sleep) |-> $stable(addr_o);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("address moved in sleep");

   property p_a0_default;
      @(posedge clk) srst |=> !a0_gpio_oe && top_gpio_oe == 4'h0;
   endproperty
   a_a0_default: assert property (p_a0_default) else $error("gpio after reset");

   property p_dram_mux;
      @(posedge clk) disable iff (srst)
         req.valid && !active_r && !sleep && req.dram |=> addr_o[16:1] == $past(req.dram_addr);
   endproperty
   a_dram_mux: assert property (p_dram_mux) else $error("dram address missing");

   property p_pullup;
      @(posedge clk) disable iff (srst) sleep |-> data_pullup == 16'hffff && data_oe == 16'h0000;
   endproperty
   a_pullup: assert property (p_pullup) else $error("sleep pull-up missing");

   property p_refresh_dwe;
      @(posedge clk) disable iff (srst) active_r && ref_r |-> pe3_o && oe_n;
   endproperty
   a_refresh_dwe: assert property (p_refresh_dwe) else $error("dram strobe low in refresh");

   property p_dwe_sel;
      @(posedge clk) disable iff (srst) pe3_oe == (sel_r[PE3_SEL_BIT] && drc_r[DWE_EN_BIT]);
   endproperty
   a_dwe_sel: assert property (p_dwe_sel) else $error("dram strobe select");

   property p_int_ack;
      @(posedge clk) disable iff (srst) active_r && !ext_r |-> cycle_ack;
   endproperty
   a_int_ack: assert property (p_int_ack) else $error("internal ack blocked");

   property p_oe_read;
      @(posedge clk) disable iff (srst) !oe_n |-> active_r && !wr_r;
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("output enable outside read");

   property p_we_lane;
      @(posedge clk) disable iff (srst)
         !strobe_mode && !lower_write_strobe_n |-> do_wr && wide_cs_r && lanes_r[0];
   endproperty
   a_we_lane: assert property (p_we_lane) else $error("lower write strobe misused");
endmodule // embp_pins

// >>> test/embp_mem_model.sv
`timescale 1ns/1ps
module embp_mem_model #(
   parameter int ACK_DLY = 3
) (
   input  wire logic        clk,
   input  wire logic [23:0] addr_o,
   input  wire logic        oe_n,
   input  wire logic        lws_n,
   input  wire logic        uws_n,
   input  wire logic [15:0] data_o,
   input  wire logic [15:0] data_oe,
   input  wire logic [15:0] data_pullup,
   input  wire logic        width_o,
   input  wire logic        width_oe,
   input  wire logic        strap_lo,
   output logic [15:0]      data_i,
   output logic             width_i
);
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0000;
   logic [15:0] fl;
   int          cnt = 0;
   // board pull-up unless strapped low, ack low after a delay
   assign width_i = width_oe ? width_o : (!strap_lo && cnt < ACK_DLY);
   // released lines toggle unless pulled up
   assign fl = oe_n ? (~last | data_pullup) : mem[addr_o[4:1]];
   assign data_i = (data_oe & data_o) | (~data_oe & fl);
   initial foreach (mem[i]) mem[i] = 16'h0000;
   always @(posedge clk) begin
      last <= data_i;
      cnt <= oe_n ? 0 : cnt + 1;
      if (oe_n && !lws_n) mem[addr_o[4:1]][7:0] <= data_o[7:0];
      if (oe_n && !uws_n) mem[addr_o[4:1]][15:8] <= data_o[15:8];
   end
endmodule // embp_mem_model

// >>> test/test_embp_pins.sv
`timescale 1ns/1ps
module test_embp_pins;
   import embp_pkg::*;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic [23:0]       reg_addr = 24'h0;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [7:0]        reg_rdata, b;
   embp_req_t         req = '0;
   embp_req_t         r;
   logic              cycle_end = 1'b0;
   logic              cycle_ack, oe_n, lws_n, uws_n, pe3_o, pe3_oe, spc_sel;
   logic              a0_oe, bw_i, bw_o, bw_oe, boot_wide;
   logic [15:0]       rdata, data_i, data_o, data_oe, data_pullup, d;
   logic [23:0]       addr_o, last_a;
   logic [3:0]        top_oe;
   logic [2:0]        legacy_pullup;
   logic [15:0]       ref_mem [16];
   logic [7:0]        seed = 8'h4e;
   logic              sm = 1'b0;
   logic              strap_lo = 1'b0;
   int                num_errors = 0;
   int                checked = 0;
   localparam logic [23:0] OFS [4] = '{SYS_CTRL_OFS, CS_CTRL1_OFS, DRAM_CTRL_OFS, PIN_SEL_OFS};
   localparam logic [7:0]  RST [4] = '{SYS_CTRL_RST, CS_CTRL1_RST, DRAM_CTRL_RST, PIN_SEL_RST};

   embp_pins dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
      .cycle_end(cycle_end), .cycle_ack(cycle_ack), .rdata(rdata), .addr_o(addr_o),
      .top_gpio_oe(top_oe), .a0_gpio_oe(a0_oe), .oe_n(oe_n), .lower_write_strobe_n(lws_n),
      .upper_write_strobe_n(uws_n), .pe3_o(pe3_o), .pe3_oe(pe3_oe),
      .serial_port_clock_sel(spc_sel), .boot_width_pin_i(bw_i), .boot_width_pin_o(bw_o),
      .boot_width_pin_oe(bw_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
      .data_pullup(data_pullup), .legacy_pullup(legacy_pullup), .boot_wide(boot_wide));
   embp_mem_model far (.clk(clk), .addr_o(addr_o), .oe_n(oe_n), .lws_n(lws_n),
      .uws_n(uws_n), .data_o(data_o), .data_oe(data_oe), .data_pullup(data_pullup),
      .width_o(bw_o), .width_oe(bw_oe), .strap_lo(strap_lo), .data_i(data_i),
      .width_i(bw_i));

   initial begin
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task chk_pin(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task reg_w(input logic [23:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task reg_r(input logic [23:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // one bus cycle, compared with the bench memory
   task cyc(input embp_req_t q);
      logic lo, up;
      int   n;
      last_a = q.dram ? {q.addr[23:17], q.dram_addr, q.addr[0]} : q.addr;
      lo = (q.write | (q.group_b & sm)) & q.lanes[0] & q.wide & !q.refresh;
      up = (q.write | (q.group_b & sm)) & q.lanes[1] & !q.refresh;
      q.valid = 1'b1;
      @(posedge clk) req <= q;
      @(posedge clk) req <= '0;
      #1;
      chk_val("addr", last_a, addr_o);
      chk_pin("oe_n", q.write | q.refresh, oe_n);
      chk_pin("lower strobe", !lo, lws_n);
      chk_pin("upper strobe", !up, uws_n);
      chk_pin("dram strobe", !(q.dram & q.write & !q.refresh), pe3_o);
      chk_pin("ack", !q.ext_ack, cycle_ack);
      n = 0;
      while (n < 3 || cycle_ack !== 1'b1) begin
         if (n == 40) begin
            chk_pin("ack wait", 1'b1, cycle_ack);
            close_out();
         end
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk) cycle_end <= 1'b1;
      @(posedge clk) cycle_end <= 1'b0;
      #1 d = rdata;
      if (lo && q.write) ref_mem[last_a[4:1]][7:0] = q.wdata[7:0];
      if (up && q.write) ref_mem[last_a[4:1]][15:8] = q.wide ? q.wdata[15:8] : q.wdata[7:0];
      if (!q.write && !q.refresh) chk_val("rdata", ref_mem[last_a[4:1]], d);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      foreach (ref_mem[i]) ref_mem[i] = 16'h0000;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk_pin("a0 gpio", 1'b0, a0_oe);
      chk_val("top gpio", 24'h0, top_oe);
      chk_val("legacy pullups", 24'h7, legacy_pullup);
      chk_pin("width oe", 1'b0, bw_oe);
      chk_pin("serial clock", 1'b1, spc_sel);
      for (int i = 0; i < 4; i++) begin
         reg_r(OFS[i], b);
         chk_val("reset value", RST[i], b);
      end
      chk_pin("boot width", 1'b1, boot_wide);
      reg_r(STATUS_OFS, b);
      chk_val("status", 24'h3, b);
      reg_r(24'hfff01c, b);
      chk_val("unmapped", 24'h0, b);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         r = '0;
         r.wide = (i != 5);
         r.lanes = (i == 5) ? 2'b10 : 2'(i % 3 + 1);
         r.addr = {12'h001, 3'b000, seed, 1'b0};
         r.wdata = {seed, lfsr(seed)};
         r.write = 1'b1;
         cyc(r);
         r.write = 1'b0;
         r.lanes = 2'b11;
         cyc(r);
      end
      $display("test bus done");
      reg_w(CS_CTRL1_OFS, 8'h01);
      sm = 1'b1;
      r.group_b = 1'b1;
      cyc(r);
      r.write = 1'b1;
      cyc(r);
      sm = 1'b0;
      reg_w(CS_CTRL1_OFS, 8'h00);
      $display("test group b done");
      reg_w(PIN_SEL_OFS, 8'h01);
      reg_w(DRAM_CTRL_OFS, 8'h01);
      #1;
      chk_pin("pe3 oe", 1'b1, pe3_oe);
      chk_pin("serial clock", 1'b0, spc_sel);
      r = '0;
      r.dram = 1'b1;
      r.wide = 1'b1;
      r.lanes = 2'b11;
      r.write = 1'b1;
      r.addr = 24'h0a5551;
      r.dram_addr = {8'h3c, lfsr(seed)};
      r.wdata = 16'hc3e1;
      cyc(r);
      r.write = 1'b0;
      cyc(r);
      r.write = 1'b1;
      r.refresh = 1'b1;
      r.lanes = 2'b00;
      cyc(r);
      r = '0;
      r.ext_ack = 1'b1;
      r.wide = 1'b1;
      r.lanes = 2'b11;
      r.addr = 24'h000022;
      cyc(r);
      $display("test dram and ack done");
      reg_w(SYS_CTRL_OFS, 8'h02);
      r.ext_ack = 1'b0;
      r.valid = 1'b1;
      @(posedge clk) req <= r;
      @(posedge clk) req <= '0;
      #1;
      chk_val("data pullups", 24'hffff, data_pullup);
      chk_val("sleep addr", last_a, addr_o);
      chk_pin("sleep oe_n", 1'b1, oe_n);
      reg_w(SYS_CTRL_OFS, 8'h00);
      reg_w(PORT_OUT_OFS, 8'h02);
      reg_w(PIN_SEL_OFS, 8'h08);
      #1;
      chk_pin("width drive", 1'b1, bw_oe);
      chk_pin("width out", 1'b1, bw_o);
      reg_w(SYS_CTRL_OFS, 8'h01);
      #1;
      chk_val("gpio oe", 24'h0002, data_oe);
      chk_val("gpio out", 24'h0002, data_o);
      $display("test sleep and pins done");
      @(posedge clk);
      srst <= 1'b1;
      strap_lo <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_pin("narrow boot width", 1'b0, boot_wide);
      chk_pin("a0 gpio again", 1'b0, a0_oe);
      $display("test second reset done");
      close_out();
   end
endmodule // test_embp_pins
